// >>> hdl/dfcnt_top.sv
// Module: two saturating up/down pulse counters with setpoint flags
// Summary of operation
// - Two counters, each on its own input
// - Counts pulse trains up to 1 kHz
// - Flag handed to scan once per cycle
// - Count only while enable is one
// - Direction zero counts up, one down
// - Clear control forces count to zero
// - No counting during clear, resume after
// - Flag high when count at or above setpoint
// - Setpoint ranges zero through 32000
// - Count saturates at 32000 and zero
// - Count held without pulses or enable
// - Flag drops at setpoint minus one
// - Retentive count survives stop and power; here sys_rst clears it to zero
// - Retention selectable for each counter
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module dfcnt_top
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Pulse inputs
   input  wire logic        pulse_input_a,
   input  wire logic        pulse_input_b,
   // Scan strobe: one pulse per program cycle
   input  wire logic        scan_tick,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Scan-side flags
   output logic             scan_flag_a,
   output logic             scan_flag_b
);

   // Synchroniser, edge and counter state
   logic [1:0]  sync1_q,  sync1_d;
   logic [1:0]  sync2_q,  sync2_d;
   logic [1:0]  prev_q,   prev_d;
   logic [14:0] count_q  [2];
   logic [14:0] count_d  [2];
   logic [14:0] setpt_q  [2];
   logic [14:0] setpt_d  [2];
   logic [1:0]  live_flag;
   logic [1:0]  scan_q,   scan_d;
   logic [15:0] ctl_q,    ctl_d;
   logic [15:0] rdata_d;
   logic [1:0]  rise;
   logic        run;
   dfcnt_pkg::dfcnt_ctl_t ctl [2];

   assign run = ctl_q[dfcnt_pkg::CTL_RUN];

   // Two-flop synchroniser; only the second stage feeds the edge detector
   always_comb
   begin
      sync1_d = {pulse_input_b, pulse_input_a};
      sync2_d = sync1_q;
      prev_d  = sync2_q;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         prev_q  <= 2'h0;
      end
      else
      begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
      end
   end

   // rising edge detect
   // The delay stage resets low like an idle line: no false edge on release
   assign rise = sync2_q & ~prev_q;

   // Per-counter datapath; the whole counter is one generate body
   for (genvar i = 0; i < dfcnt_pkg::N_CNT; i++)
   begin : g_cnt
      // Pick each field by its bit position, not by struct order, so the
      // enable stays in bit 0 of its nibble as software expects
      localparam int unsigned BASE = i * dfcnt_pkg::CTL_STRIDE;
      assign ctl[i] = {ctl_q[BASE + dfcnt_pkg::CTL_EN],
                       ctl_q[BASE + dfcnt_pkg::CTL_DIR],
                       ctl_q[BASE + dfcnt_pkg::CTL_CLR],
                       ctl_q[BASE + dfcnt_pkg::CTL_RET]};

      always_comb
      begin
         count_d[i] = count_q[i];
         // clear checked first, beats an edge
         if (ctl[i].clear)
            count_d[i] = dfcnt_pkg::CNT_ZERO;
         // a stop drops a non-retentive count
         else if (!run && !ctl[i].retain)
            count_d[i] = dfcnt_pkg::CNT_ZERO;
         // each counter sees only its own input
         // one edge per two PHASE_CYC spans is easily seen
         else if (run && ctl[i].enable && rise[i])
         begin
            if (!ctl[i].direction)
            begin
               if (count_q[i] != dfcnt_pkg::CNT_MAX)
                  count_d[i] = count_q[i] + dfcnt_pkg::CNT_ONE;
            end
            else if (count_q[i] != dfcnt_pkg::CNT_ZERO)
               count_d[i] = count_q[i] - dfcnt_pkg::CNT_ONE;
         end
      end

      // compare live; follows at setpoint minus one
      assign live_flag[i] = (count_q[i] >= setpt_q[i]);

      always_ff @(posedge clk or posedge sys_rst)
      begin
         if (sys_rst)
            count_q[i] <= dfcnt_pkg::CNT_ZERO;
         else
            count_q[i] <= count_d[i];
      end

      // Assertions guarding each counter
      a_clear_zero: assert property (@(posedge clk) disable iff (sys_rst)
         ctl[i].clear |=> count_q[i] == dfcnt_pkg::CNT_ZERO)
         else $error("count not zero after clear");
      a_clear_wins: assert property (@(posedge clk) disable iff (sys_rst)
         (ctl[i].clear && rise[i]) |=> count_q[i] == 15'h0000)
         else $error("edge beat clear");
      a_max_hold: assert property (@(posedge clk) disable iff (sys_rst)
         count_q[i] <= dfcnt_pkg::CNT_MAX)
         else $error("count above ceiling");
      a_count_up: assert property (@(posedge clk) disable iff (sys_rst)
         (run && !ctl[i].clear && ctl[i].enable && !ctl[i].direction
          && rise[i] && count_q[i] < dfcnt_pkg::CNT_MAX)
         |=> count_q[i] == $past(count_q[i]) + 15'h0001)
         else $error("up count wrong");
      a_count_down: assert property (@(posedge clk) disable iff (sys_rst)
         (run && !ctl[i].clear && ctl[i].enable && ctl[i].direction
          && rise[i] && count_q[i] > 15'h0000)
         |=> count_q[i] == $past(count_q[i]) - 15'h0001)
         else $error("down count wrong");
      a_hold_idle: assert property (@(posedge clk) disable iff (sys_rst)
         (!ctl[i].clear && (run || ctl[i].retain)
          && !(ctl[i].enable && rise[i]))
         |=> $stable(count_q[i]))
         else $error("count moved while idle");
      a_retain_stop: assert property (@(posedge clk) disable iff (sys_rst)
         (!run && ctl[i].retain && !ctl[i].clear)
         |=> $stable(count_q[i]))
         else $error("retained count lost");
      a_scan_flag: assert property (@(posedge clk) disable iff (sys_rst)
         scan_tick |=> scan_q[i] == $past(live_flag[i]))
         else $error("scan flag not latched");
      a_scan_hold: assert property (@(posedge clk) disable iff (sys_rst)
         !scan_tick |=> $stable(scan_q[i]))
         else $error("scan flag moved between scans");
      a_rise_sync: assert property (
         @(posedge clk) disable iff (sys_rst)
         $rose(sync1_q[i]) |=> rise[i])
         else $error("synchronised edge missed");
      a_flag_set: assert property (
         @(posedge clk) disable iff (sys_rst)
         (scan_tick && count_q[i] >= setpt_q[i]) |=> scan_q[i])
         else $error("scan flag missed at setpoint");
      a_flag_clear: assert property (
         @(posedge clk) disable iff (sys_rst)
         (scan_tick && count_q[i] < setpt_q[i]) |=> !scan_q[i])
         else $error("scan flag stuck below setpoint");
      a_floor_hold: assert property (
         @(posedge clk) disable iff (sys_rst)
         (run && ctl[i].enable && ctl[i].direction && !ctl[i].clear
          && rise[i] && count_q[i] == dfcnt_pkg::CNT_ZERO)
         |=> count_q[i] == dfcnt_pkg::CNT_ZERO)
         else $error("count wrapped below zero");
      a_stop_clear: assert property (
         @(posedge clk) disable iff (sys_rst)
         (!run && !ctl[i].retain) |=> count_q[i] == dfcnt_pkg::CNT_ZERO)
         else $error("non-retentive count kept in stop");
      a_input_own: assert property (
         @(posedge clk) disable iff (sys_rst)
         (run && !ctl[i].clear && !rise[i]) |=> $stable(count_q[i]))
         else $error("count moved without its own edge");
   end

   // flags pass to the scan only on its tick, so lag up to a cycle
   // A crossing that reverts before the next tick is never reported
   always_comb
   begin
      scan_d = scan_q;
      if (scan_tick)
         scan_d = live_flag;
   end

   // Register writes; setpoints above the ceiling are clipped
   always_comb
   begin
      ctl_d      = ctl_q;
      setpt_d[0] = setpt_q[0];
      setpt_d[1] = setpt_q[1];
      if (reg_wr)
      begin
         unique case (reg_addr)
            dfcnt_pkg::ADDR_CTRL:   ctl_d = reg_wdata;
            dfcnt_pkg::ADDR_SETPT0: setpt_d[0] =
               (reg_wdata[14:0] > dfcnt_pkg::CNT_MAX || reg_wdata[15])
               ? dfcnt_pkg::CNT_MAX : reg_wdata[14:0];
            dfcnt_pkg::ADDR_SETPT1: setpt_d[1] =
               (reg_wdata[14:0] > dfcnt_pkg::CNT_MAX || reg_wdata[15])
               ? dfcnt_pkg::CNT_MAX : reg_wdata[14:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read zero
   // Data stand for one cycle only; a master that waits longer sees zero
   always_comb
   begin
      rdata_d = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            dfcnt_pkg::ADDR_CTRL:   rdata_d = ctl_q;
            dfcnt_pkg::ADDR_SETPT0: rdata_d = {1'b0, setpt_q[0]};
            dfcnt_pkg::ADDR_SETPT1: rdata_d = {1'b0, setpt_q[1]};
            dfcnt_pkg::ADDR_COUNT0: rdata_d = {1'b0, count_q[0]};
            dfcnt_pkg::ADDR_COUNT1: rdata_d = {1'b0, count_q[1]};
            dfcnt_pkg::ADDR_STAT:   rdata_d = {14'h0000, live_flag};
            dfcnt_pkg::ADDR_SCAN:   rdata_d = {14'h0000, scan_q};
            default:                rdata_d = 16'h0000;
         endcase
      end
   end

   // retain bit held per counter in the control word
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctl_q      <= dfcnt_pkg::CTL_RST;
         setpt_q[0] <= dfcnt_pkg::CNT_ZERO;
         setpt_q[1] <= dfcnt_pkg::CNT_ZERO;
         scan_q     <= 2'h0;
         reg_rdata  <= 16'h0000;
      end
      else
      begin
         ctl_q      <= ctl_d;
         setpt_q[0] <= setpt_d[0];
         setpt_q[1] <= setpt_d[1];
         scan_q     <= scan_d;
         reg_rdata  <= rdata_d;
      end
   end

   // Register port assertions
   // control word lands
   a_ctl_write: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == dfcnt_pkg::ADDR_CTRL)
      |=> ctl_q == $past(reg_wdata))
      else $error("control write lost");
   a_setpt_write: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == dfcnt_pkg::ADDR_SETPT0
       && reg_wdata <= {1'b0, dfcnt_pkg::CNT_MAX})
      |=> setpt_q[0] == $past(reg_wdata[14:0]))
      else $error("setpoint write lost");
   a_setpt_clip: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == dfcnt_pkg::ADDR_SETPT1 && reg_wdata[15])
      |=> setpt_q[1] == dfcnt_pkg::CNT_MAX)
      else $error("setpoint not clipped");
   // Read data stand one cycle only
   a_rdata_idle: assert property (
      @(posedge clk) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data left standing");
   a_rdata_unmap: assert property (
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr > dfcnt_pkg::ADDR_SCAN) |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");

   // Flags leave straight from the scan latch
   assign scan_flag_a = scan_q[0];
   assign scan_flag_b = scan_q[1];

endmodule : dfcnt_top

// >>> hdl/dfcnt_pkg.sv
// Package: constants and carrier types for the dual fast up/down counter
package dfcnt_pkg;
   localparam int unsigned CNT_W      = 15;
   localparam logic [14:0] CNT_MAX    = 15'h7D00;   // 32000
   localparam logic [14:0] CNT_ZERO   = 15'h0000;
   localparam logic [14:0] CNT_ONE    = 15'h0001;
   localparam int unsigned N_CNT      = 2;
   // Source limits, used only for cycle figures
   localparam real         CLK_MHZ    = 10.0;
   localparam real         F_MAX_KHZ  = 1.0;
   localparam real         T_PHASE_MS = 0.5;
   localparam int unsigned PHASE_CYC  =
      int'($ceil(T_PHASE_MS * 1000.0 * CLK_MHZ));
   // Register map of the plain port
   localparam logic [3:0]  ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_SETPT0 = 4'h1;
   localparam logic [3:0]  ADDR_SETPT1 = 4'h2;
   localparam logic [3:0]  ADDR_COUNT0 = 4'h3;
   localparam logic [3:0]  ADDR_COUNT1 = 4'h4;
   localparam logic [3:0]  ADDR_STAT   = 4'h5;
   localparam logic [3:0]  ADDR_SCAN   = 4'h6;
   // Control word field positions (per counter, 4 bits apart)
   localparam int unsigned CTL_EN     = 0;
   localparam int unsigned CTL_DIR    = 1;
   localparam int unsigned CTL_CLR    = 2;
   localparam int unsigned CTL_RET    = 3;
   localparam int unsigned CTL_STRIDE = 4;
   localparam int unsigned CTL_RUN    = 8;
   localparam logic [15:0] CTL_RST    = 16'h0000;
   // Per-counter control carrier
   typedef struct packed {
      logic enable;
      logic direction;
      logic clear;
      logic retain;
   } dfcnt_ctl_t;
endpackage : dfcnt_pkg

// >>> tb/dfcnt_src.sv
// Pulse source model standing on one counter input
`timescale 1ns/100ps
module dfcnt_src
#(
   parameter int PH = 4   // Phase in clocks; far below 0.5 ms to keep runs short
)
(
   // Clock and pulse line
   input  wire logic clk,
   output logic      line
);
   initial line = 1'b0;
   task automatic send(input int n);
      repeat (n)
      begin
         repeat (PH) @(posedge clk);
         line <= 1'b1;
         repeat (PH) @(posedge clk);
         line <= 1'b0;
      end
      repeat (PH) @(posedge clk);   // Low tail covers the sync latency
   endtask : send
endmodule : dfcnt_src

// >>> tb/dfcnt_top_tb.sv
// Self-checking bench for the dual fast up/down counter
`timescale 1ns/100ps
module dfcnt_top_tb;
   logic        clk, sys_rst, pa, pb, scan_tick, reg_wr, reg_rd;
   logic [3:0]  reg_addr, ua;
   logic [15:0] reg_wdata, reg_rdata, ud;
   logic        scan_flag_a, scan_flag_b;
   int          num_errors, total_checks, s, n;
   // Device and two pulse sources
   dfcnt_top DUT (.clk(clk), .sys_rst(sys_rst), .pulse_input_a(pa),
      .pulse_input_b(pb), .scan_tick(scan_tick), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .scan_flag_a(scan_flag_a),
      .scan_flag_b(scan_flag_b));
   dfcnt_src src_a (.clk(clk), .line(pa));
   dfcnt_src src_b (.clk(clk), .line(pb));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input string w, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", w, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr
   // Read data is looked at only in the cycle after the strobe
   task automatic rchk(input string w, input logic [3:0] a,
                       input logic [15:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      check(w, reg_rdata, e);
   endtask : rchk
   task automatic tick;
      @(posedge clk);
      scan_tick <= 1'b1;
      @(posedge clk);
      scan_tick <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : tick
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : test_done
   // Hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      num_errors++;
      test_done();
   end
   // Main sequence
   initial
   begin
      sys_rst = 1'b1;
      scan_tick = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      num_errors = 0;
      total_checks = 0;
      s = $urandom(42);
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0000);
      rchk("unmapped", 4'hF, 16'h0000);
      $display("test reset done");
      // Count up to a random setpoint; flag waits for the scan
      s = 2 + $urandom % 5;
      wr(dfcnt_pkg::ADDR_SETPT0, 16'(s));
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0101);
      src_a.send(s);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'(s));
      check("scan_a", 16'(scan_flag_a), 16'h0000);
      tick();
      check("scan_a", 16'(scan_flag_a), 16'h0001);
      $display("test up done");
      // One step down drops the live flag at setpoint minus one
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0103);
      src_a.send(1);
      rchk("live", dfcnt_pkg::ADDR_STAT, 16'h0002);
      check("scan_a", 16'(scan_flag_a), 16'h0001);
      tick();
      check("scan_a", 16'(scan_flag_a), 16'h0000);
      $display("test down done");
      // Pulses without enable are ignored and the count holds
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0102);
      src_a.send(2);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'(s - 1));
      $display("test hold done");
      // Clear ignores pulses, floor holds, counting resumes
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0105);
      src_a.send(2);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0000);
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0103);
      src_a.send(1);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0000);
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0101);
      src_a.send(1);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0001);
      $display("test clear done");
      // Second counter runs on its own input only
      n = 2 + $urandom % 3;
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0110);
      src_b.send(n);
      rchk("count_b", dfcnt_pkg::ADDR_COUNT1, 16'(n));
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0001);
      tick();
      check("scan_b", 16'(scan_flag_b), 16'h0001);
      wr(dfcnt_pkg::ADDR_SETPT1, 16'hFFFF);
      rchk("setpt_b", dfcnt_pkg::ADDR_SETPT1, 16'h7D00);
      tick();
      check("scan_b", 16'(scan_flag_b), 16'h0000);
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0130);
      src_b.send(1);
      rchk("count_b", dfcnt_pkg::ADDR_COUNT1, 16'(n - 1));
      $display("test second done");
      // Stop keeps only the retentive count, run continues from it
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0089);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0001);
      rchk("count_b", dfcnt_pkg::ADDR_COUNT1, 16'(n - 1));
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0009);
      rchk("count_b", dfcnt_pkg::ADDR_COUNT1, 16'h0000);
      wr(dfcnt_pkg::ADDR_CTRL, 16'h0109);
      src_a.send(1);
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0002);
      $display("test retain done");
      // Unmapped writes change nothing and unmapped reads give zero
      ua = 4'h7 + 4'($urandom % 9);
      ud = 16'($urandom);
      wr(ua, ud);
      rchk("ctrl", dfcnt_pkg::ADDR_CTRL, 16'h0109);
      rchk("unmapped", ua, 16'h0000);
      $display("test unmapped done");
      // Mid-run reset clears everything; next read at first edge after
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rchk("count_a", dfcnt_pkg::ADDR_COUNT0, 16'h0000);
      rchk("ctrl", dfcnt_pkg::ADDR_CTRL, 16'h0000);
      check("scan_a", 16'(scan_flag_a), 16'h0000);
      $display("test reset again done");
      test_done();
   end
endmodule : dfcnt_top_tb
